// [alu_mul_div_shifter_tb_top.sv]
/* Self-checking bench: ALU, multiply, divide and shift over APB.
   Assumes amd_pkg, amd_regs.svh, the design and amd_apb_model. */
`include "amd_regs.svh"
module alu_mul_div_shifter_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import amd_pkg::*;
   localparam logic [11:0] CMD = `AMD_CMD_OFS, ST = `AMD_STAT_OFS, CT = `AMD_CTRL_OFS;
   localparam logic [11:0] MOP = `AMD_MOP_OFS, MR = `AMD_MRES_OFS;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   int failures = 0;
   int cmp_count = 0;
   int cycles = 0;

   amd_alu_top u_amd_alu_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   amd_apb_model u_amd_apb_model (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic tally_and_finish;
      $display("counts: %0d compares, %0d mismatches", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish

   // Whole run needs roughly 1000 cycles
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         failures++;
         tally_and_finish;
      end
   end

   function automatic logic [11:0] w(input int n);
      return 12'h040 + 12'(n * 4);
   endfunction : w

   function automatic logic [31:0] mk(amd_op_e op, logic bm, logic sm, logic dm,
                                      logic [3:0] ra, logic [3:0] rb, logic [3:0] rd, logic [4:0] lit);
      amd_cmd_s c;
      c = '{7'h00, lit, rd, rb, ra, dm, sm, bm, op};
      return c;
   endfunction : mk

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
   endtask : chk

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      u_amd_apb_model.xfer(1'b1, a, d, r, e);
      chk({31'h0, e}, 32'h0000_0000);
   endtask : wr

   task automatic rdc(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      u_amd_apb_model.xfer(1'b0, a, 32'h0000_0000, r, e);
      chk(r, x);
   endtask : rdc

   task automatic alu(amd_op_e op, logic bm, logic [15:0] a, logic [15:0] b, logic [15:0] s0,
                      logic [15:0] res, logic [15:0] st);
      wr(w(2), {16'h0000, a});
      wr(w(3), {16'h0000, b});
      wr(w(4), 32'h0000_ABCD);
      wr(ST, {16'h0000, s0});
      wr(CMD, mk(op, bm, 1'b0, 1'b0, 4'h2, 4'h3, 4'h4, 5'h00));
      rdc(w(4), {16'h0000, res});
      rdc(ST, {16'h0000, st});
   endtask : alu

   task automatic mul(amd_op_e op, logic bm, logic [15:0] a, logic [15:0] b, logic [4:0] lit,
                      logic [31:0] p);
      wr(w(2), {16'h0000, a});
      wr(w(3), {16'h0000, b});
      wr(w(5), 32'h0000_1234);
      wr(CMD, mk(op, bm, 1'b0, 1'b0, 4'h2, 4'h3, 4'h4, lit));
      rdc(w(4), {16'h0000, p[15:0]});
      rdc(w(5), {16'h0000, bm ? 16'h1234 : p[31:16]});
   endtask : mul

   task automatic sh(amd_op_e op, logic [15:0] a, logic [3:0] n, logic [15:0] res);
      wr(w(2), {16'h0000, a});
      wr(w(3), {28'h000_0000, n});
      wr(CMD, mk(op, 1'b0, 1'b1, 1'b1, 4'h2, 4'h3, 4'h4, 5'h00));
      rdc(w(4), {16'h0000, res});
      rdc(MR, 32'h0000_0000);
   endtask : sh

   task automatic dv(amd_op_e op, logic [15:0] hi, logic [15:0] lo, logic [15:0] d,
                     logic [15:0] q, logic [15:0] r);
      logic [31:0] rr;
      logic e;
      wr(ST, 32'h0000_0000);
      wr(w(3), {16'h0000, hi});
      wr(w(2), {16'h0000, lo});
      wr(w(6), {16'h0000, d});
      wr(CMD, mk(op, 1'b0, 1'b0, 1'b0, 4'h2, 4'h6, 4'h0, 5'h00));
      rdc(ST, 32'h0001_0000);
      u_amd_apb_model.xfer(1'b1, CMD, 32'h0000_0000, rr, e);
      chk({31'h0, e}, 32'h0000_0001);
      wr(CT, 32'h0000_0001);
      repeat (40) @(posedge pclk);
      rdc(ST, 32'h0001_0000);
      wr(CT, 32'h0000_0000);
      repeat (19) @(posedge pclk);
      rdc(ST, 32'h0000_0000);
      rdc(w(0), {16'h0000, q});
      rdc(w(1), {16'h0000, r});
   endtask : dv

   task automatic t_alu;
      rdc(ST, 32'h0000_0000);
      alu(op_add, 1'b0, 16'h7FFF, 16'h0001, 16'h0000, 16'h8000, 16'h010C);
      alu(op_sub, 1'b0, 16'h0005, 16'h0005, 16'h0000, 16'h0000, 16'h0103);
      alu(op_sub, 1'b0, 16'h0000, 16'h0001, 16'h0000, 16'hFFFF, 16'h0008);
      alu(op_add, 1'b1, 16'h127F, 16'h0001, 16'h0000, 16'hAB80, 16'h010C);
      alu(op_add, 1'b1, 16'h12FF, 16'h0001, 16'h0000, 16'hAB00, 16'h0103);
      alu(op_addc, 1'b0, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
      alu(op_addc, 1'b0, 16'h0000, 16'h0000, 16'h0003, 16'h0001, 16'h0000);
      alu(op_subb, 1'b0, 16'h0005, 16'h0005, 16'h0001, 16'h0000, 16'h0101);
      alu(op_and, 1'b0, 16'hF0F0, 16'h0F0F, 16'h0005, 16'h0000, 16'h0007);
      alu(op_ior, 1'b0, 16'h8000, 16'h0001, 16'h0000, 16'h8001, 16'h0008);
      alu(op_xor, 1'b0, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000, 16'h0002);
      $display("alu test done");
   endtask : t_alu

   task automatic t_mul;
      mul(op_mul_ss, 1'b0, 16'hFFFF, 16'hFFFF, 5'h00, 32'h0000_0001);
      mul(op_mul_uu, 1'b0, 16'hFFFF, 16'hFFFF, 5'h00, 32'hFFFE_0001);
      mul(op_mul_us, 1'b0, 16'hFFFF, 16'hFFFF, 5'h00, 32'hFFFF_0001);
      mul(op_mul_sl, 1'b0, 16'hFFFF, 16'h0000, 5'h1F, 32'hFFFF_FFE1);
      mul(op_mul_ul, 1'b0, 16'hFFFF, 16'h0000, 5'h1F, 32'h001E_FFE1);
      mul(op_mul_uu, 1'b1, 16'h12FF, 16'h34FF, 5'h00, 32'h0000_FE01);
      $display("multiply test done");
   endtask : t_mul

   task automatic t_shift;
      sh(arith_right_shift_op, 16'h8001, 4'hF, 16'hFFFF);
      sh(logical_right_shift_op, 16'h8001, 4'hF, 16'h0001);
      sh(left_shift_op, 16'h8001, 4'hF, 16'h8000);
      sh(arith_right_shift_op, 16'h8001, 4'h1, 16'hC000);
      wr(w(4), 32'h0000_5A5A);
      wr(w(2), 32'h0000_1280);
      wr(w(3), 32'h0000_0001);
      wr(CMD, mk(arith_right_shift_op, 1'b1, 1'b0, 1'b0, 4'h2, 4'h3, 4'h4, 5'h00));
      rdc(w(4), 32'h0000_5AC0);
      rdc(ST, 32'h0000_0008);
      $display("shift test done");
   endtask : t_shift

   task automatic t_div;
      dv(op_div_sd, 16'hFFFF, 16'hFF9C, 16'h0007, 16'hFFF2, 16'hFFFE);
      dv(op_div_ud, 16'h0001, 16'h0000, 16'h0003, 16'h5555, 16'h0001);
      dv(op_div_sw, 16'h1234, 16'hFF9C, 16'h0007, 16'hFFF2, 16'hFFFE);
      dv(op_div_uw, 16'h1234, 16'hFF9C, 16'h0007, 16'h2484, 16'h0000);
      $display("divide test done");
   endtask : t_div

   task automatic t_mem_bad;
      logic [31:0] r;
      logic e;
      wr(MOP, 32'h0000_0010);
      wr(w(2), 32'h0000_0020);
      wr(CMD, mk(op_add, 1'b0, 1'b1, 1'b1, 4'h2, 4'h3, 4'h4, 5'h00));
      rdc(MR, 32'h0000_0030);
      u_amd_apb_model.xfer(1'b0, 12'h020, 32'h0000_0000, r, e);
      chk({r[30:0], e}, 32'h0000_0001);
      u_amd_apb_model.xfer(1'b1, 12'h006, 32'h0000_FFFF, r, e);
      chk({31'h0, e}, 32'h0000_0001);
      $display("memory and unmapped test done");
   endtask : t_mem_bad

   initial begin
      presetn = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_alu;
      t_mul;
      t_shift;
      t_div;
      t_mem_bad;
      tally_and_finish;
   end
endmodule : alu_mul_div_shifter_tb_top

// [amd_alu_top.sv]
/*
 * 16-bit ALU, 17x17 multiplier, iterative divider and barrel shifter with a
 * 16-entry working register array, a status word, and a memory operand and
 * result word, all reached over an APB slave.
 * Assumes an APB master on pclk; one wait state on every transfer.
 */
// Our own choices: the placing of the registers and the APB interface to the registers.
`include "amd_regs.svh"

// Summary of operation
// RULE1: Sixteen-bit datapath: add, subtract, shifts, logic; arithmetic is two's complement.
// RULE2: Operations update carry, zero, negative, overflow and half-carry in the status word.
// RULE3: On subtraction carry means no borrow, half-carry means no digit borrow.
// RULE4: Each operation runs byte or word wide as the command selects; divides ignore the byte bit and run word wide.
// RULE5: Operands from working registers or memory word; results to either.
// RULE6: Multiplier operands are seventeen bits, sign- or zero-extended from sixteen.
// RULE7: Multiply modes: SxS, UxU, UxS, S or U times 5-bit literal, byte UxU.
// RULE8: Divide 32 or 16 bit dividend by 16 bit divisor, signed or unsigned.
// RULE9: Divide result: quotient into register zero, remainder into register one.
// RULE10: Divisor from any register; 32-bit dividend from even pair, odd holds top.
// RULE11: Divider iterates one cycle per divisor bit for both dividend sizes.
// RULE12: Barrel shifter shifts right arithmetic or left by up to fifteen in one cycle.
// RULE13: Multi-bit shifts read and write working registers only, never memory.
// RULE14: Shifts: arithmetic right, logical right and left, by one or more places.
// RULE15: Divide completes in nineteen cycles; can pause at any cycle and resume.
// RULE16: Every multiply completes in one cycle.
// RULE17: Half-carry is carry out of bit 3 in byte mode, bit 7 in word mode.
// RULE18: Extended add and subtract clear zero on non-zero but never set it.
// RULE19: Byte operations take flags from the 8-bit result and carry out of bit 7.
// RULE20: Overflow set when the signed result leaves the selected width's range.
module amd_alu_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import amd_pkg::*;

   function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
      hit = addr == ofs;
   endfunction : hit

   function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) m[8*i +: 8] = wd[8*i +: 8];
      end
      merge_bytes = m;
   endfunction : merge_bytes

   logic [15:0] wreg [16];
   amd_cmd_s cmd;
   amd_flags_s flags;
   logic exec, hold;
   logic [15:0] mem_operand, mem_result;

   // APB decode
   wire access = psel && penable;
   wire rd_phase = access && !pready;
   wire wr_commit = access && pready && pwrite && !pslverr;
   wire is_w = paddr[11:6] == `AMD_WREG_PAGE && paddr[1:0] == 2'h0;
   wire [3:0] w_idx = paddr[5:2];
   wire hit_cmd = hit(paddr, `AMD_CMD_OFS);
   wire hit_ctrl = hit(paddr, `AMD_CTRL_OFS);
   wire hit_stat = hit(paddr, `AMD_STAT_OFS);
   wire hit_mop = hit(paddr, `AMD_MOP_OFS);
   wire hit_mres = hit(paddr, `AMD_MRES_OFS);
   wire mapped = is_w || hit_cmd || hit_ctrl || hit_stat || hit_mop || hit_mres;

   wire div_busy, div_done;
   wire [15:0] div_q, div_r;
   wire busy = exec || div_busy;

   wire [31:0] status_word = (32'(flags.c) << `AMD_ST_C) | (32'(flags.z) << `AMD_ST_Z) |
                             (32'(flags.ov) << `AMD_ST_OV) | (32'(flags.n) << `AMD_ST_N) |
                             (32'(flags.dc) << `AMD_ST_DC) | (32'(busy) << `AMD_ST_BUSY);
   wire [31:0] rd_mux = is_w ? {16'h0000, wreg[w_idx]} :
                        hit_cmd ? 32'(cmd) :
                        hit_ctrl ? (32'(hold) << `AMD_CTRL_HOLD) :
                        hit_stat ? status_word :
                        hit_mop ? {16'h0000, mem_operand} :
                        hit_mres ? {16'h0000, mem_result} : 32'h0000_0000;
   wire [31:0] wr_val = merge_bytes(rd_mux, pwdata, pstrb);
   // A new command while one is running is refused, not queued
   wire refuse = !mapped || (pwrite && hit_cmd && busy);
   wire cmd_we = wr_commit && hit_cmd;

   // Operation classes
   amd_op_e op;
   assign op = cmd.op;
   wire byte_op = cmd.byte_mode;
   wire is_sub = op inside {op_sub, op_subb};
   wire is_arith = op inside {op_add, op_addc, op_sub, op_subb};
   wire is_logic = op inside {op_and, op_ior, op_xor};
   wire is_shift = op inside {arith_right_shift_op, logical_right_shift_op, left_shift_op};
   wire is_mul = op inside {op_mul_ss, op_mul_uu, op_mul_us, op_mul_sl, op_mul_ul};
   wire is_div = op inside {op_div_sd, op_div_ud, op_div_sw, op_div_uw};
   wire flag_op = is_arith || is_logic || is_shift;

   // Operands; shifts never take the memory word
   wire [15:0] opa = wreg[cmd.ra];
   wire [15:0] opb_w = wreg[cmd.rb];
   wire [15:0] opb = (cmd.srcb_mem && !is_shift) ? mem_operand : opb_w; // [RULE5] [RULE13]

   // Adder, subtract as a + ~b + cin
   wire cin = (op == op_addc || op == op_subb) ? flags.c : is_sub;
   wire [15:0] bb = is_sub ? ~opb : opb; // [RULE1]
   wire [16:0] sum17 = {1'b0, opa} + {1'b0, bb} + 17'(cin); // [RULE1]
   wire [8:0] byte9 = {1'b0, opa[7:0]} + {1'b0, bb[7:0]} + 9'(cin);
   wire [4:0] nib5 = {1'b0, opa[3:0]} + {1'b0, bb[3:0]} + 5'(cin);

   // Shifter, amount from the low bits of the second register
   wire [15:0] sh_res;
   wire sh_c;
   amd_shift_e sh_kind;
   assign sh_kind = (op == arith_right_shift_op) ? sh_asr : (op == logical_right_shift_op) ? sh_lsr : sh_sl;
   amd_shifter #(.W(16)) u_shift (
      .operand(opa),
      .amount(opb_w[3:0]),
      .kind(sh_kind),
      .byte_mode(byte_op),
      .result(sh_res),
      .carry_out(sh_c)
   ); // [RULE12] [RULE14]

   wire [15:0] alu_res = is_arith ? sum17[15:0] : is_shift ? sh_res :
                         (op == op_and) ? (opa & opb) : (op == op_ior) ? (opa | opb) : (opa ^ opb);

   // Flags, byte mode looks at bit 7 and the low byte only
   wire r_msb = byte_op ? alu_res[7] : alu_res[15]; // [RULE19]
   wire a_msb = byte_op ? opa[7] : opa[15];
   wire b_msb = byte_op ? bb[7] : bb[15];
   wire r_zero = byte_op ? alu_res[7:0] == 8'h00 : alu_res == 16'h0000; // [RULE19]
   wire ovf = (a_msb == b_msb) && (r_msb != a_msb); // [RULE20]
   wire sticky_z = op inside {op_addc, op_subb};
   amd_flags_s next_flags;
   assign next_flags = '{
      dc: is_arith ? (byte_op ? nib5[4] : byte9[8]) : flags.dc, // [RULE17] [RULE3]
      n: r_msb, // [RULE2]
      ov: is_arith ? ovf : flags.ov, // [RULE20]
      z: sticky_z ? (flags.z && r_zero) : r_zero, // [RULE18]
      c: is_arith ? (byte_op ? byte9[8] : sum17[16]) : is_shift ? sh_c : flags.c // [RULE3] [RULE19]
   };

   // 17x17 signed array; unsigned inputs are zero-extended
   wire a_s = op inside {op_mul_ss, op_mul_sl};
   wire b_s = op inside {op_mul_ss, op_mul_us};
   wire b_lit = op inside {op_mul_sl, op_mul_ul};
   wire [16:0] ma = byte_op ? {9'h000, opa[7:0]} : {a_s & opa[15], opa}; // [RULE6] [RULE7]
   wire [16:0] mb = b_lit ? {12'h000, cmd.lit} : byte_op ? {9'h000, opb[7:0]} : {b_s & opb[15], opb}; // [RULE7]
   wire signed [33:0] prod_full = $signed(ma) * $signed(mb); // [RULE6]
   wire [31:0] prod = prod_full[31:0];

   // Register write-back from an executing command
   wire [3:0] lo_idx = {cmd.rd[3:1], 1'b0};
   wire [3:0] hi_idx = {cmd.rd[3:1], 1'b1};
   wire [3:0] exec_widx = is_mul ? lo_idx : cmd.rd;
   wire [15:0] exec_old = wreg[exec_widx];
   wire [15:0] exec_wdata = is_mul ? prod[15:0] : byte_op ? {exec_old[15:8], alu_res[7:0]} : alu_res; // [RULE4]
   wire to_mem = cmd.dst_mem && (is_arith || is_logic);
   wire exec_w_we = exec && (is_mul || is_shift || ((is_arith || is_logic) && !cmd.dst_mem)); // [RULE5] [RULE16]
   wire mul_hi_we = exec && is_mul && !byte_op;

   // Divide, 16-bit dividend extended to the 32-bit path
   wire div_signed = op inside {op_div_sd, op_div_sw};
   wire [31:0] dividend = (op inside {op_div_sd, op_div_ud}) ? {wreg[{cmd.ra[3:1], 1'b1}], wreg[{cmd.ra[3:1], 1'b0}]} :
                          {div_signed ? {16{opa[15]}} : 16'h0000, opa}; // [RULE10]
   amd_divider #(.W(16)) u_div (
      .clk(pclk),
      .rstn(presetn),
      .start(exec && is_div),
      .hold(hold),
      .signed_op(div_signed),
      .dividend(dividend),
      .divisor(opb_w),
      .busy(div_busy),
      .done(div_done),
      .quotient(div_q),
      .remainder(div_r)
   ); // [RULE8] [RULE10]

   for (genvar i = 0; i < 16; i++) begin : g_wreg
      wire div_we = div_done && (i < 2);
      wire ex_lo = exec_w_we && exec_widx == 4'(i);
      wire ex_hi = mul_hi_we && hi_idx == 4'(i);
      wire sw_we = wr_commit && is_w && w_idx == 4'(i);
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) wreg[i] <= `AMD_W_RST;
         else if (div_we) wreg[i] <= (i == 0) ? div_q : div_r; // [RULE9]
         else if (ex_lo) wreg[i] <= exec_wdata;
         else if (ex_hi) wreg[i] <= prod[31:16]; // [RULE16]
         else if (sw_we) wreg[i] <= wr_val[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd <= amd_cmd_s'(`AMD_CMD_RST);
         exec <= 1'b0;
         hold <= 1'b0;
      end else begin
         exec <= cmd_we;
         if (cmd_we) cmd <= amd_cmd_s'(wr_val);
         if (wr_commit && hit_ctrl) hold <= wr_val[`AMD_CTRL_HOLD]; // [RULE15]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= '0;
         mem_operand <= `AMD_MEM_RST;
         mem_result <= `AMD_MEM_RST;
      end else begin
         if (exec && flag_op) flags <= next_flags; // [RULE2]
         else if (wr_commit && hit_stat) flags <= '{dc: wr_val[`AMD_ST_DC], n: wr_val[`AMD_ST_N],
                                                   ov: wr_val[`AMD_ST_OV], z: wr_val[`AMD_ST_Z],
                                                   c: wr_val[`AMD_ST_C]};
         if (exec && to_mem) mem_result <= byte_op ? {mem_result[15:8], alu_res[7:0]} : alu_res; // [RULE5]
         if (wr_commit && hit_mop) mem_operand <= wr_val[15:0];
      end
   end

   // One wait state; read data and error fixed in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= rd_phase;
         if (rd_phase) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= refuse;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
      rd_phase |=> pready ##1 !pready)
      else $error("pready not a single cycle after one wait");

   a_add_carry: assert property (@(posedge pclk) disable iff (!presetn)
      exec && op == op_add && !byte_op |=> flags.c == $past(sum17[16])) // [RULE2]
      else $error("add carry flag wrong");

   a_sub_borrow: assert property (@(posedge pclk) disable iff (!presetn)
      exec && op == op_sub && !byte_op && opa >= opb |=> flags.c) // [RULE3]
      else $error("subtract without borrow left carry clear");

   a_half_carry: assert property (@(posedge pclk) disable iff (!presetn)
      exec && op == op_add && !byte_op && ({1'b0, opa[7:0]} + {1'b0, opb[7:0]}) >= 9'h100 |=> flags.dc) // [RULE17]
      else $error("half carry missed on bit 7 carry");

   a_zero_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      exec && sticky_z && !flags.z |=> !flags.z) // [RULE18]
      else $error("extended op set the zero flag");

   a_word_ovf: assert property (@(posedge pclk) disable iff (!presetn)
      exec && op == op_add && !byte_op && opa[15] == opb[15] && alu_res[15] != opa[15] |=> flags.ov) // [RULE20]
      else $error("signed overflow not flagged");

   a_byte_keep: assert property (@(posedge pclk) disable iff (!presetn)
      exec && byte_op && (is_arith || is_logic) && !cmd.dst_mem && !div_done
      |=> wreg[$past(exec_widx)][15:8] == $past(exec_old[15:8])) // [RULE4]
      else $error("byte op changed upper byte");

   a_mul_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
      exec && is_mul |=> wreg[$past(lo_idx)] == $past(prod[15:0]) && !busy) // [RULE16]
      else $error("multiply result not written in one cycle");

   a_div_result: assert property (@(posedge pclk) disable iff (!presetn)
      div_done |=> wreg[0] == $past(div_q) && wreg[1] == $past(div_r)) // [RULE9]
      else $error("divide result not in registers zero and one");

   a_asr_word: assert property (@(posedge pclk) disable iff (!presetn)
      exec && op == arith_right_shift_op && !byte_op
      |=> $signed(wreg[$past(cmd.rd)]) == ($signed($past(opa)) >>> $past(opb_w[3:0]))) // [RULE12]
      else $error("arithmetic right shift result wrong");

endmodule : amd_alu_top

// [amd_apb_model.sv]
/* APB master standing in for the core side, one transfer task.
   Assumes an APB slave on pclk; a hang is cut by the bench. */
module amd_apb_model (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
   end

   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= 4'hf;
      @(posedge pclk);
      penable <= 1'b1;
      // Request held until pready is seen at an edge
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Stale data must not look valid once released
      pwdata <= ~d;
   endtask : xfer
endmodule : amd_apb_model

// [amd_divider.sv]
/*
 * Iterative signed/unsigned divider, 32/16 or 16/16 (dividend given
 * extended to 32 bits), restoring, one quotient bit per cycle.
 * Assumes start is a one-cycle pulse while idle; hold freezes all state once a divide has started.
 */
`include "amd_regs.svh"

module amd_divider #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic start,
   input wire logic hold,
   input wire logic signed_op,
   input wire logic [2*W-1:0] dividend,
   input wire logic [W-1:0] divisor,
   output logic busy,
   output logic done,
   output logic [W-1:0] quotient,
   output logic [W-1:0] remainder
);
   import amd_pkg::*;

   localparam int CW = $clog2(W);
   localparam logic [CW-1:0] LAST = CW'(W - 1);

   amd_div_state_e state;
   logic [CW-1:0] cnt;
   logic [2*W-1:0] dvd;
   logic [W-1:0] dsr, rem, lo;
   logic neg_q, neg_r;
   logic [4:0] run_cyc;

   wire [2*W-1:0] dvd_mag = (signed_op && dvd[2*W-1]) ? -dvd : dvd;
   wire [W-1:0] dsr_mag = (signed_op && dsr[W-1]) ? -dsr : dsr;
   wire [W:0] trial = {rem, lo[W-1]};
   wire fits = trial >= {1'b0, dsr};
   wire [W:0] diff = trial - {1'b0, dsr};

   // Hold keeps every register, so an interrupted divide resumes exactly
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= dv_idle;
         cnt <= '0;
         dvd <= '0;
         dsr <= '0;
         rem <= '0;
         lo <= '0;
         neg_q <= 1'b0;
         neg_r <= 1'b0;
      end else if (state == dv_idle) begin
         if (start) begin
            dvd <= dividend; // [RULE8]
            dsr <= divisor;
            state <= dv_load;
         end
      end else if (!hold) begin // [RULE15]
         case (state)
            dv_load: begin
               rem <= dvd_mag[2*W-1:W];
               lo <= dvd_mag[W-1:0];
               dsr <= dsr_mag;
               neg_q <= signed_op && (dvd[2*W-1] ^ dsr[W-1]);
               neg_r <= signed_op && dvd[2*W-1];
               cnt <= '0;
               state <= dv_iter;
            end
            dv_iter: begin
               rem <= fits ? diff[W-1:0] : trial[W-1:0]; // [RULE11]
               lo <= {lo[W-2:0], fits};
               cnt <= cnt + 1'b1;
               if (cnt == LAST) begin
                  state <= dv_fix;
               end
            end
            dv_fix: state <= dv_idle;
            default: state <= dv_idle;
         endcase
      end
   end

   assign busy = state != dv_idle;
   assign done = state == dv_fix && !hold;
   assign quotient = neg_q ? -lo : lo;
   assign remainder = neg_r ? -rem : rem;

   // Unheld cycles since start, start cycle counted as one
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) run_cyc <= '0;
      else if (start && !busy) run_cyc <= 5'h01;
      else if (busy && !hold) run_cyc <= run_cyc + 5'h01;
   end

   a_div_length: assert property (@(posedge clk) disable iff (!rstn)
      done |-> run_cyc == 5'(`AMD_DIV_CYCLES - 1)) // [RULE15]
      else $error("divide did not finish in its cycle count");

   a_div_hold_freeze: assert property (@(posedge clk) disable iff (!rstn)
      (busy && hold && state != dv_idle) |=> $stable(lo) && $stable(rem) && $stable(cnt)) // [RULE15]
      else $error("divider state moved during hold");

endmodule : amd_divider

// [amd_pkg.sv]
/*
 * Types shared by the ALU block: operation codes, shift kinds, divider
 * states, the command word and the status flags.
 * Assumes nothing of its surroundings.
 */
package amd_pkg;

   typedef enum logic [4:0] {
      op_add, op_addc, op_sub, op_subb, op_and, op_ior, op_xor,
      arith_right_shift_op, logical_right_shift_op, left_shift_op,
      op_mul_ss, op_mul_uu, op_mul_us, op_mul_sl, op_mul_ul,
      op_div_sd, op_div_ud, op_div_sw, op_div_uw
   } amd_op_e;

   typedef enum logic [1:0] {sh_asr, sh_lsr, sh_sl} amd_shift_e;

   typedef enum logic [1:0] {dv_idle, dv_load, dv_iter, dv_fix} amd_div_state_e;

   typedef struct packed {
      logic [6:0] rsvd;
      logic [4:0] lit;
      logic [3:0] rd;
      logic [3:0] rb;
      logic [3:0] ra;
      logic dst_mem;
      logic srcb_mem;
      logic byte_mode;
      amd_op_e op;
   } amd_cmd_s;

   typedef struct packed {
      logic dc;
      logic n;
      logic ov;
      logic z;
      logic c;
   } amd_flags_s;

endpackage : amd_pkg

// [amd_regs.svh]
/*
 * Register offsets, field positions, reset values and cycle counts of the
 * 16-bit ALU, multiplier, divider and shifter block.
 * Assumes a 12-bit APB byte address and 32-bit data words.
 */
`ifndef AMD_REGS_SVH
`define AMD_REGS_SVH

`define AMD_CMD_OFS 12'h000
`define AMD_CTRL_OFS 12'h004
`define AMD_STAT_OFS 12'h008
`define AMD_MOP_OFS 12'h00C
`define AMD_MRES_OFS 12'h010
// Working registers at 0x040 + 4*n, picked out by paddr[11:6]
`define AMD_WREG_PAGE 6'h01

`define AMD_CMD_RST 32'h0000_0000
`define AMD_W_RST 16'h0000
`define AMD_MEM_RST 16'h0000

`define AMD_CTRL_HOLD 0
`define AMD_ST_C 0
`define AMD_ST_Z 1
`define AMD_ST_OV 2
`define AMD_ST_N 3
`define AMD_ST_DC 8
`define AMD_ST_BUSY 16

`define AMD_CLK_NS 20
`define AMD_DIV_CYCLES 19
`define AMD_MUL_CYCLES 1

`endif

// [amd_shifter.sv]
/*
 * Single-cycle barrel shifter: arithmetic right, logical right and left
 * by 0 to 15 places, word or byte wide, with the last bit shifted out.
 * Assumes operand and amount are stable for the cycle; purely combinational.
 */
module amd_shifter #(
   parameter int W = 16
) (
   input wire logic [W-1:0] operand,
   input wire logic [3:0] amount,
   input wire amd_pkg::amd_shift_e kind,
   input wire logic byte_mode,
   output logic [W-1:0] result,
   output logic carry_out
);
   import amd_pkg::*;

   // Byte mode: upper half filled so right shifts bring in the right bit
   wire fill = byte_mode && kind == sh_asr && operand[7];
   wire [W-1:0] src = byte_mode ? {{(W - 8){fill}}, operand[7:0]} : operand;
   wire signed [W:0] rwide = $signed({src, 1'b0});
   // Own signed net: inside an unsigned ternary the shift would turn logical
   wire signed [W:0] asr_w = rwide >>> amount;
   wire [W:0] rsh = (kind == sh_asr) ? asr_w : {src, 1'b0} >> amount; // [RULE14]
   wire [W:0] lsh = {1'b0, src} << amount; // [RULE12]

   assign result = (kind == sh_sl) ? lsh[W-1:0] : rsh[W:1];
   assign carry_out = (kind == sh_sl) ? (byte_mode ? lsh[8] : lsh[W]) : rsh[0];

endmodule : amd_shifter
